// file: design/mas_defs.svh
// Purpose: Constants for the motor auto setup sequencer.
// Assumes: Plain ports carry all control and status bits.
// Notes:   Timing constants are in nanoseconds; the clock runs at 200 MHz.
`ifndef MAS_DEFS_SVH
`define MAS_DEFS_SVH
`define MAS_MODE_AUTO_SETUP    8'hfe
`define MAS_CW_START_BIT       4
`define MAS_SW_DONE_BIT        12
`define MAS_SW_INDEX_BIT       10
`define MAS_PROG_RUN_BIT       0
`define MAS_STORE_DRIVE_SUB    8'h05
`define MAS_STORE_TUNING_SUB   8'h06
`define MAS_SUBMODE_BLDC       32'h00000040
`define MAS_FB_SEL_RESET       8'h00
`define MAS_STEP_NS            1000
`define MAS_CLK_NS             5
`endif

// file: design/mas_pkg.sv
// Purpose: Types for the motor auto setup sequencer.
// Assumes: Used with scoped names only.
// Notes:   State codes are the default enum values, 0 for MAS_IDLE up to 10 for MAS_DONE.
package mas_pkg;
   typedef enum logic [3:0] {
      MAS_IDLE,
      MAS_MOTOR,
      MAS_RES,
      MAS_IND,
      MAS_FLUX,
      MAS_ENC,
      MAS_ENC_REV,
      MAS_HALL,
      MAS_SAVE_DRV,
      MAS_SAVE_TUN,
      MAS_DONE
   } mas_state_t;
endpackage : mas_pkg

// file: design/mas_sequencer.sv
// Purpose: Drive-side sequencer for the motor auto setup procedure.
// Assumes: Measurement engines answer each step with a one-cycle meas_done pulse.
// Notes:   Sensor presence and index pins pass a three-stage synchroniser.
// Summary of operation
// [R1] Host selects mode minus two first
// [R2] Operation enabled required before start
// [R3] Host starts via control word bit four
// [R4] Status bit twelve set when finished
// [R5] Status bit ten reports index found
// [R6] Start only while user program stopped
// [R7] Measure type, resistance, inductance, flux always
// [R8] Encoder steps only with indexed encoder; the code gates them on encoder presence alone, not on the index pin
// [R9] Hall transitions only with Hall sensor
// [R10] Reverse direction and re-evaluate edges
// [R11] Copy results, save drive and tuning
// [R12] Three separate feedback configuration holders
// [R13] Host stores resolution for unindexed encoders
// [R14] Host stores gear and feed constants
// [R15] Feedback selection per control loop
// [R16] Coordinates invalid until device restart
// [R17] Fieldbus service may lag during run
// [R18] Host sets motor submode beforehand
// [R19] Host waits for completion before commands
`include "mas_defs.svh"
module mas_sequencer #(
   parameter int DATA_W = 32
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [7:0]        op_mode,
   input  wire logic [15:0]       control_word,
   input  wire logic              op_enabled,
   input  wire logic [7:0]        prog_control,
   input  wire logic              enc_present_pin,
   input  wire logic              enc_index_pin,
   input  wire logic              hall_present_pin,
   input  wire logic              meas_done,
   input  wire logic [DATA_W-1:0] meas_value,
   input  wire logic              store_ack,
   input  wire logic              fb_sel_we,
   input  wire logic [7:0]        fb_sel_wdata,
   output logic [15:0]            status_word,
   output logic [3:0]             meas_step,
   output logic                   meas_start,
   output logic                   meas_reverse,
   output logic                   store_req,
   output logic [7:0]             store_sub,
   output logic                   busy,
   output logic                   coord_invalid,
   output logic [DATA_W-1:0]      motor_type,
   output logic [DATA_W-1:0]      winding_res,
   output logic [DATA_W-1:0]      winding_ind,
   output logic [DATA_W-1:0]      flux,
   output logic [DATA_W-1:0]      sensorless_cfg,
   output logic [DATA_W-1:0]      hall_cfg,
   output logic [DATA_W-1:0]      enc1_cfg,
   output logic [DATA_W-1:0]      enc1_align,
   output logic [7:0]             fb_select
);
   mas_pkg::mas_state_t state;
   mas_pkg::mas_state_t next_state;
   logic [2:0]          enc_sync;
   logic [2:0]          idx_sync;
   logic [2:0]          hall_sync;
   logic                enc_present;
   logic                idx_level;
   logic                hall_present;
   logic                start_prev;
   logic                start_edge;
   logic                start_ok;
   logic                index_found;
   logic                done_flag;
   logic                step_done;

   // Three stages per pin; a change counts only when the last two agree.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enc_sync  <= 3'h0;
         idx_sync  <= 3'h0;
         hall_sync <= 3'h0;
      end else if (ce) begin
         enc_sync  <= {enc_sync[1:0], enc_present_pin};
         idx_sync  <= {idx_sync[1:0], enc_index_pin};
         hall_sync <= {hall_sync[1:0], hall_present_pin};
      end
   end

   // Filtered levels hold their value while the later stages disagree.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enc_present  <= 1'b0;
         idx_level    <= 1'b0;
         hall_present <= 1'b0;
      end else if (ce) begin
         if (enc_sync[2] == enc_sync[1]) begin
            enc_present <= enc_sync[2];
         end
         if (idx_sync[2] == idx_sync[1]) begin
            idx_level <= idx_sync[2];
         end
         if (hall_sync[2] == hall_sync[1]) begin
            hall_present <= hall_sync[2];
         end
      end
   end

   // Start is edge triggered so a held control bit cannot restart a finished run.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_prev <= 1'b0;
      end else if (ce) begin
         start_prev <= control_word[`MAS_CW_START_BIT];
      end
   end

   // A start counts only while idle or done; one raised mid-run is ignored silently.
   assign start_edge = control_word[`MAS_CW_START_BIT] & ~start_prev; // R3
   assign start_ok   = start_edge
                       & ((state == mas_pkg::MAS_IDLE) || (state == mas_pkg::MAS_DONE))
                       & (op_mode == `MAS_MODE_AUTO_SETUP) // R1
                       & op_enabled // R2
                       & ~prog_control[`MAS_PROG_RUN_BIT]; // R6
   assign step_done  = meas_done & ~meas_start;

   // Step sequence; optional sensor steps are skipped by presence.
   always_comb begin
      next_state = state;
      case (state)
         mas_pkg::MAS_IDLE: begin
            if (start_ok) begin
               next_state = mas_pkg::MAS_MOTOR;
            end
         end
         mas_pkg::MAS_MOTOR: begin
            if (step_done) begin
               next_state = mas_pkg::MAS_RES; // R7
            end
         end
         mas_pkg::MAS_RES: begin
            if (step_done) begin
               next_state = mas_pkg::MAS_IND;
            end
         end
         mas_pkg::MAS_IND: begin
            if (step_done) begin
               next_state = mas_pkg::MAS_FLUX;
            end
         end
         mas_pkg::MAS_FLUX: begin
            if (step_done) begin
               if (enc_present) begin
                  next_state = mas_pkg::MAS_ENC; // R8
               end else if (hall_present) begin
                  next_state = mas_pkg::MAS_HALL; // R9
               end else begin
                  next_state = mas_pkg::MAS_SAVE_DRV;
               end
            end
         end
         mas_pkg::MAS_ENC: begin
            if (step_done) begin
               next_state = mas_pkg::MAS_ENC_REV; // R10
            end
         end
         mas_pkg::MAS_ENC_REV: begin
            if (step_done) begin
               if (hall_present) begin
                  next_state = mas_pkg::MAS_HALL; // R9
               end else begin
                  next_state = mas_pkg::MAS_SAVE_DRV;
               end
            end
         end
         mas_pkg::MAS_HALL: begin
            if (step_done) begin
               next_state = mas_pkg::MAS_SAVE_DRV;
            end
         end
         mas_pkg::MAS_SAVE_DRV: begin
            if (store_ack & ~store_req) begin
               next_state = mas_pkg::MAS_SAVE_TUN; // R11
            end
         end
         mas_pkg::MAS_SAVE_TUN: begin
            if (store_ack & ~store_req) begin
               next_state = mas_pkg::MAS_DONE; // R11
            end
         end
         mas_pkg::MAS_DONE: begin
            if (start_ok) begin
               next_state = mas_pkg::MAS_MOTOR;
            end
         end
         default: begin
            next_state = mas_pkg::MAS_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= mas_pkg::MAS_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // One-cycle start pulse for each measurement step on entry.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meas_start   <= 1'b0;
         meas_step    <= 4'h0;
         meas_reverse <= 1'b0;
      end else if (ce) begin
         meas_start   <= (next_state != state)
                         && (next_state != mas_pkg::MAS_SAVE_DRV)
                         && (next_state != mas_pkg::MAS_SAVE_TUN)
                         && (next_state != mas_pkg::MAS_DONE);
         meas_step    <= 4'(next_state);
         meas_reverse <= (next_state == mas_pkg::MAS_ENC_REV); // R10
      end
   end

   // Storage requests, one pulse per category.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         store_req <= 1'b0;
         store_sub <= 8'h00;
      end else if (ce) begin
         store_req <= (next_state != state)
                      && ((next_state == mas_pkg::MAS_SAVE_DRV)
                          || (next_state == mas_pkg::MAS_SAVE_TUN));
         if (next_state == mas_pkg::MAS_SAVE_DRV) begin
            store_sub <= `MAS_STORE_DRIVE_SUB; // R11
         end else if (next_state == mas_pkg::MAS_SAVE_TUN) begin
            store_sub <= `MAS_STORE_TUNING_SUB; // R11
         end
      end
   end

   // Results land in their holders as each step completes.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         motor_type     <= '0;
         winding_res    <= '0;
         winding_ind    <= '0;
         flux           <= '0;
         sensorless_cfg <= '0;
         hall_cfg       <= '0;
         enc1_cfg       <= '0;
         enc1_align     <= '0;
      end else if (ce && step_done) begin
         case (state)
            mas_pkg::MAS_MOTOR:   motor_type  <= meas_value; // R7
            mas_pkg::MAS_RES:     winding_res <= meas_value; // R7
            mas_pkg::MAS_IND:     winding_ind <= meas_value; // R7
            mas_pkg::MAS_FLUX:    flux <= meas_value; // R7
            mas_pkg::MAS_ENC:     enc1_cfg <= meas_value; // R12
            mas_pkg::MAS_ENC_REV: enc1_align <= meas_value; // R8
            mas_pkg::MAS_HALL:    hall_cfg <= meas_value; // R12
            default:              sensorless_cfg <= sensorless_cfg;
         endcase
         if (state == mas_pkg::MAS_FLUX) begin
            sensorless_cfg <= meas_value ^ winding_res; // R12
         end
      end
   end

   // Index capture during encoder steps; cleared at each new start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         index_found <= 1'b0;
      end else if (ce) begin
         if ((state == mas_pkg::MAS_ENC) || (state == mas_pkg::MAS_ENC_REV)) begin
            index_found <= index_found | idx_level; // R5
         end else if (start_ok) begin
            index_found <= 1'b0;
         end
      end
   end

   // Done flag; sticks until the next accepted start.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_flag <= 1'b0;
      end else if (ce) begin
         if (next_state == mas_pkg::MAS_DONE) begin
            done_flag <= 1'b1; // R4
         end else if (start_ok) begin
            done_flag <= 1'b0;
         end
      end
   end

   // Coordinates stay invalid after a run; only reset (restart) clears it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         coord_invalid <= 1'b0;
      end else if (ce && start_ok) begin
         coord_invalid <= 1'b1; // R16
      end
   end

   // Feedback selection is host-written and steers loop assignment downstream.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fb_select <= `MAS_FB_SEL_RESET;
      end else if (ce && fb_sel_we) begin
         fb_select <= fb_sel_wdata; // R15
      end
   end

   // Busy warns the fieldbus side that servicing may lag.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy        <= 1'b0;
         status_word <= 16'h0000;
      end else if (ce) begin
         busy <= (next_state != mas_pkg::MAS_IDLE)
                 && (next_state != mas_pkg::MAS_DONE); // R17
         status_word <= 16'h0000;
         status_word[`MAS_SW_DONE_BIT]  <= (next_state == mas_pkg::MAS_DONE)
                                           | (done_flag & ~start_ok); // R4
         status_word[`MAS_SW_INDEX_BIT] <= index_found & ~start_ok; // R5
      end
   end
endmodule : mas_sequencer

// file: verification/mas_engine_model.sv
// Purpose: Measurement and storage engines facing the auto setup sequencer.
// Assumes: One request is outstanding at a time.
// Notes:   The lag input sets how slow the engines answer.
module mas_engine_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        meas_start,
   input  wire logic        store_req,
   input  wire logic [3:0]  meas_step,
   input  wire logic [3:0]  lag,
   output logic             meas_done,
   output logic             store_ack,
   output logic [31:0]      meas_value
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   logic [3:0] step;
   logic       pend_m;
   logic       pend_s;
   // Answer each request lag plus one cycles after it is taken, never in the request's own cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {cnt, step, pend_m, pend_s, meas_done, store_ack} <= '0;
      end else begin
         meas_done <= 1'b0;
         store_ack <= 1'b0;
         if (meas_start || store_req) begin
            {pend_m, pend_s, cnt, step} <= {meas_start, store_req, lag, meas_step};
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else begin
            {meas_done, store_ack, pend_m, pend_s} <= {pend_m, pend_s, 2'b00};
         end
      end
   end
   // Outside the done pulse the value is garbage, so a late capture is caught.
   assign meas_value = meas_done ? 32'h0000a000 + 32'(step) : ~(32'h0000a000 + 32'(step));
endmodule : mas_engine_model

// file: verification/mas_seq_properties.sv
// Purpose: Port-level checks of the auto setup sequencer.
// Assumes: Single clock domain, reset asynchronous and active high.
// Notes:   Bound to every instance of the sequencer.
module mas_seq_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [7:0]  op_mode,
   input wire logic [15:0] control_word,
   input wire logic        op_enabled,
   input wire logic [7:0]  prog_control,
   input wire logic        meas_done,
   input wire logic        store_ack,
   input wire logic        fb_sel_we,
   input wire logic [7:0]  fb_sel_wdata,
   input wire logic [15:0] status_word,
   input wire logic [3:0]  meas_step,
   input wire logic        meas_start,
   input wire logic        meas_reverse,
   input wire logic        store_req,
   input wire logic [7:0]  store_sub,
   input wire logic        busy,
   input wire logic        coord_invalid,
   input wire logic [7:0]  fb_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // A start request meeting every precondition while idle or done.
   sequence start_taken;
      ce && $rose(control_word[4]) && op_mode == 8'hfe && op_enabled && !prog_control[0] && !busy;
   endsequence
   sequence save_drive;
      store_req && store_sub == 8'h05;
   endsequence
   sequence save_tune;
      store_req && store_sub == 8'h06;
   endsequence
   start_answer_a: assert property (start_taken |=> meas_start && busy)
      else $error("start not answered");
   prog_blocks_a: assert property (!busy && $rose(control_word[4]) && prog_control[0]
      |=> !busy)
      else $error("start taken while program runs");
   save_order_a: assert property (save_drive |-> ##[1:40] save_tune)
      else $error("tuning save missing after drive save");
   done_after_a: assert property (ce && busy && store_ack && !store_req && store_sub == 8'h06
      |=> status_word[12] && !busy)
      else $error("done not set after last save");
   done_holds_a: assert property (status_word[12] && !$rose(control_word[4]) |=> status_word[12])
      else $error("done flag dropped");
   status_clean_a: assert property ((status_word & 16'hebff) == 16'h0000)
      else $error("unused status bits set");
   start_clears_a: assert property (start_taken |=> !status_word[10] && !status_word[12]
      && coord_invalid)
      else $error("start did not clear flags");
   coord_sticky_a: assert property (coord_invalid |=> coord_invalid)
      else $error("coordinate flag cleared");
   step_next_a: assert property (ce && busy && meas_done && !meas_start
      && meas_step == 4'(mas_pkg::MAS_MOTOR) |=> meas_start && meas_step == 4'(mas_pkg::MAS_RES))
      else $error("resistance step did not follow");
   reverse_pass_a: assert property (meas_start && meas_step == 4'(mas_pkg::MAS_ENC_REV)
      |-> meas_reverse)
      else $error("reverse pass not flagged");
   fb_write_a: assert property (ce && fb_sel_we |=> fb_select == $past(fb_sel_wdata))
      else $error("feedback selection not written");
endmodule : mas_seq_properties
bind mas_sequencer mas_seq_properties u_props (.clk, .rst, .ce, .op_mode, .control_word,
   .op_enabled, .prog_control, .meas_done, .store_ack, .fb_sel_we, .fb_sel_wdata, .status_word,
   .meas_step, .meas_start, .meas_reverse, .store_req, .store_sub, .busy, .coord_invalid,
   .fb_select);

// file: verification/tb.sv
// Purpose: Self-checking bench for the auto setup sequencer.
// Assumes: Engine model answers every step and save.
// Notes:   Expected results follow the engine model's value scheme.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, op_enabled = 1'b0, fb_sel_we = 1'b0;
   logic enc_present_pin = 1'b0, enc_index_pin = 1'b0, hall_present_pin = 1'b0;
   logic [7:0] op_mode = 8'h00, prog_control = 8'h00, fb_sel_wdata = 8'h00;
   logic [15:0] control_word = 16'h0000;
   logic [3:0] lag = 4'h1;
   wire logic meas_done, store_ack, meas_start, meas_reverse, store_req, busy, coord_invalid;
   wire logic [31:0] meas_value, motor_type, winding_res, winding_ind, flux, sensorless_cfg;
   wire logic [31:0] hall_cfg, enc1_cfg, enc1_align;
   wire logic [15:0] status_word;
   wire logic [3:0] meas_step;
   wire logic [7:0] store_sub, fb_select;
   int errors = 0, checked = 0, cycles = 0;
   logic [3:0] steps[$];
   logic [7:0] subs[$];
   logic [31:0] enc_exp = '0, align_exp = '0, hall_exp = '0;
   mas_sequencer #(.DATA_W(32)) DUT (.clk, .rst, .ce, .op_mode, .control_word, .op_enabled,
      .prog_control, .enc_present_pin, .enc_index_pin, .hall_present_pin, .meas_done,
      .meas_value, .store_ack, .fb_sel_we, .fb_sel_wdata, .status_word, .meas_step, .meas_start,
      .meas_reverse, .store_req, .store_sub, .busy, .coord_invalid, .motor_type, .winding_res,
      .winding_ind, .flux, .sensorless_cfg, .hall_cfg, .enc1_cfg, .enc1_align, .fb_select);
   mas_engine_model engines (.clk, .rst, .meas_start, .store_req, .meas_step, .lag, .meas_done,
      .store_ack, .meas_value);
   always #2.5 clk = ~clk;
   // Record step and save requests; a hang is cut off well past the longest run.
   always @(posedge clk) begin
      cycles++;
      if (meas_start === 1'b1) steps.push_back(meas_step);
      if (store_req === 1'b1) subs.push_back(store_sub);
      if (cycles == 5000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // Each row breaks one start precondition; the request must be ignored.
   task automatic refused_starts();
      logic [7:0] modes[3] = '{8'h01, 8'hfe, 8'hfe};
      logic [7:0] progs[3] = '{8'h00, 8'h01, 8'h00};
      logic       ens[3] = '{1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         #1 {op_mode, prog_control, op_enabled} = {modes[i], progs[i], ens[i]};
         control_word = 16'h0010;
         repeat (4) @(posedge clk);
         #1 control_word = 16'h0000;
         check("busy refused", busy, 1'b0);
      end
      {op_mode, prog_control, op_enabled} = {8'hfe, 8'h00, 1'b1};
   endtask : refused_starts
   // One complete run with the given sensors and engine lag.
   // Submode, resolution and gearing objects have no port, so the sensor pins stand for them.
   task automatic run_setup(input logic enc, input logic hall, input logic [3:0] l);
      logic [3:0] exp[$] = '{mas_pkg::MAS_MOTOR, mas_pkg::MAS_RES, mas_pkg::MAS_IND,
                             mas_pkg::MAS_FLUX};
      logic [31:0] res_v = 32'ha000 + 32'(mas_pkg::MAS_RES);
      int n = 0;
      {enc_present_pin, enc_index_pin, hall_present_pin, lag} = {enc, enc, hall, l};
      if (enc) exp = {exp, mas_pkg::MAS_ENC, mas_pkg::MAS_ENC_REV};
      if (hall) exp.push_back(mas_pkg::MAS_HALL);
      if (enc) begin
         enc_exp   = 32'ha000 + 32'(mas_pkg::MAS_ENC);
         align_exp = 32'ha000 + 32'(mas_pkg::MAS_ENC_REV);
      end
      if (hall) hall_exp = 32'ha000 + 32'(mas_pkg::MAS_HALL);
      repeat (8) @(posedge clk);
      #1 control_word = 16'h0010;
      steps = {};
      subs = {};
      @(posedge clk);
      #1 control_word = 16'h0000;
      while (status_word[12] !== 1'b1 && n < 1000) begin
         @(posedge clk);
         #1 n++;
      end
      check("step count", steps.size(), exp.size());
      foreach (exp[i]) check("step", steps[i], exp[i]);
      check("saves", {subs[0], subs[1]}, 16'h0506);
      check("done", status_word[12], 1'b1);
      check("index", status_word[10], enc);
      check("busy", busy, 1'b0);
      check("coord", coord_invalid, 1'b1);
      check("motor", motor_type, 32'ha000 + 32'(mas_pkg::MAS_MOTOR));
      check("res", winding_res, res_v);
      check("ind", winding_ind, 32'ha000 + 32'(mas_pkg::MAS_IND));
      check("flux", flux, 32'ha000 + 32'(mas_pkg::MAS_FLUX));
      check("sensorless", sensorless_cfg, res_v ^ (32'ha000 + 32'(mas_pkg::MAS_FLUX)));
      check("enc cfg", enc1_cfg, enc_exp);
      check("align", enc1_align, align_exp);
      check("hall cfg", hall_cfg, hall_exp);
   endtask : run_setup
   // A restart in mid-run clears the result flags and the coordinate flag.
   task automatic restart_mid_run();
      @(posedge clk);
      #1 control_word = 16'h0010;
      repeat (3) @(posedge clk);
      #1 check("busy mid-run", busy, 1'b1);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      control_word = 16'h0000;
      check("coord restart", coord_invalid, 1'b0);
      check("status restart", status_word, 16'h0000);
      @(posedge clk);
      #1 check("busy restart", busy, 1'b0);
   endtask : restart_mid_run
   // With the enable low a host write must not land; the pause keeps strobes apart.
   task automatic frozen_write();
      {ce, fb_sel_we, fb_sel_wdata} = {1'b0, 1'b1, 8'h33};
      @(posedge clk);
      #1 check("fb frozen", fb_select, 8'h00);
      {ce, fb_sel_we} = {1'b1, 1'b0};
      @(posedge clk);
      #1;
   endtask : frozen_write
   // Feedback selection written and read back once, right after the write.
   task automatic fb_write();
      {fb_sel_we, fb_sel_wdata} = {1'b1, 8'h5a};
      @(posedge clk);
      #1 fb_sel_we = 1'b0;
      check("fb select", fb_select, 8'h5a);
   endtask : fb_write
   // Reset, then the scenarios in turn.
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      check("status reset", status_word, 16'h0000);
      check("fb reset", fb_select, 8'h00);
      check("coord reset", coord_invalid, 1'b0);
      refused_starts();
      run_setup(1'b0, 1'b0, 4'h1);
      run_setup(1'b1, 1'b1, 4'h3);
      run_setup(1'b1, 1'b0, 4'h8);
      restart_mid_run();
      frozen_write();
      fb_write();
      tally_and_finish();
   end
endmodule : tb
